// file: rtl/scwd_decoder.sv
// configuration word store and field decoder for an inductive sensor front end
// assumes a same-clock register master and coil samples from same-clock adc logic
// What this block does
// - gain field top bit is polarity, lower three bits give magnitude
// - gain code zero is nominal, 1000 minimum, 0111 maximum, steps about 3%
// - tail current code gives normal, half, quarter, eighth; feedback always on
// - update-rate codes 011..110 divide the clock by 8, 16, 32, 64 for adcs
// - pwm frequency equals adc update rate when pwm output is selected
// - filter bit 0 picks sinc alone, 1 picks sinc then fir
// - swap bit set exchanges sine and cosine coil inputs
// - seven-bit signed gain mismatch correction between the two channels
// - ten-bit signed dynamic offset for first coil, split over two words
// - ten-bit signed static offset for the first coil channel
// - ten-bit signed offset for second coil, split over two words
// - ten-bit signed dynamic offset for second coil, split over two words
// - hold eleven-bit frame length count and one-bit pause pulse enable
// - one bit selects the error check method of psi frames
// - two-bit threshold-detect source select, default zero
`timescale 1ns/1ps
`default_nettype none
`include "scwd_consts.svh"

module scwd_decoder
	import scwd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic [12:0] first_coil_input,
	input wire logic [12:0] second_coil_input,
	output logic cfg_ready,
	output logic cfg_reserved_code,
	output logic gain_polarity,
	output logic [2:0] gain_magnitude,
	output logic [3:0] amplifier_gain_adjust,
	output logic [1:0] tail_current_shift,
	output logic osc_feedback_enable,
	output logic [2:0] update_rate_select,
	output logic adc_sample_tick,
	output logic pwm_period_tick,
	output logic digital_filter_fir,
	output logic [12:0] cosine_path,
	output logic [12:0] sine_path,
	output logic signed [6:0] gain_mismatch_correction,
	output logic signed [9:0] ch1_dynamic_offset,
	output logic signed [9:0] ch1_static_offset,
	output logic signed [9:0] ch2_offset_a,
	output logic signed [9:0] ch2_offset_b,
	output logic [3:0] serial_protocol_select,
	output logic [10:0] frame_length_ticks,
	output logic pause_pulse_enable,
	output logic psi_error_check_select,
	output logic [1:0] threshold_source_select,
	output logic [14:0] output_selection,
	output logic [2:0] watchdog_scale
);
	scwd_word_type word_r [0:31];
	scwd_state_type state_r;
	logic [5:0] load_cnt_r;
	logic [5:0] div_cnt_r;
	logic [5:0] div_limit;
	logic [2:0] div_shift;
	logic rate_reserved;
	logic code_reserved;
	logic proto_reserved;
	logic psi_frame_reserved;
	logic psi_status_reserved;
	logic region_b_reserved;
	logic region_a_reserved;
	logic [15:0] w_an;
	logic [15:0] w_ca;
	logic [15:0] w_cb;
	logic [15:0] w_cc;
	logic [15:0] w_cd;
	logic [15:0] w_se;
	logic [15:0] w_pa;
	logic [15:0] w_pb;
	logic [15:0] w_oc;
	logic running;

	function automatic scwd_word_type rst_word(input logic [4:0] idx);
		scwd_word_type v;
		v = 16'h0000;
		case (idx)
			`SCWD_W_ANALOG: v = `SCWD_RST_ANALOG;
			`SCWD_W_OUTPUT_SELECTION: v = `SCWD_RST_OUTPUT_SELECTION;
			`SCWD_W_USER_MESSAGE_ID: v = `SCWD_RST_USER_MESSAGE_ID;
			`SCWD_W_MISC: v = `SCWD_RST_MISC;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	assign w_an = word_r[`SCWD_W_ANALOG];
	assign w_ca = word_r[`SCWD_W_CORR_A];
	assign w_cb = word_r[`SCWD_W_CORR_B];
	assign w_cc = word_r[`SCWD_W_CORR_C];
	assign w_cd = word_r[`SCWD_W_CORR_D];
	assign w_se = word_r[`SCWD_W_SERIAL];
	assign w_pa = word_r[`SCWD_W_PSI_A];
	assign w_pb = word_r[`SCWD_W_PSI_B];
	assign w_oc = word_r[`SCWD_W_OSC];
	assign running = (state_r == SCWD_RUN);

	// the whole store is written verbatim; reserved and id bits are the
	// writer's to preserve, so no read-modify-write is done here
	// verbatim word store
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < `SCWD_WORD_COUNT; i++) begin
				word_r[i] <= rst_word(5'(i));
			end
		end else if (reg_wr) begin
			word_r[reg_addr] <= reg_wdata;
		end
	end

	// every index is mapped, so a read always answers with a word
	// zero outside the answer cycle, so read data can be or-ed onto a shared bus
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= word_r[reg_addr];
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// fixed load time stands in for the copy out of the slow store
	// load before use
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_r <= SCWD_LOAD;
			load_cnt_r <= 6'h00;
		end else begin
			case (state_r)
				SCWD_LOAD: begin
					load_cnt_r <= load_cnt_r + 6'h01;
					if (load_cnt_r == `SCWD_LOAD_CYCLES - 6'h01) begin
						state_r <= SCWD_RUN;
					end
				end
				SCWD_RUN: begin
					load_cnt_r <= load_cnt_r;
				end
				default: begin
					state_r <= SCWD_LOAD;
					load_cnt_r <= 6'h00;
				end
			endcase
		end
	end

	// lags the run state by one cycle so it rises with the first loaded shadows
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_ready <= 1'b0;
		end else begin
			cfg_ready <= running;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			gain_polarity <= 1'b0;
			gain_magnitude <= 3'h0;
			amplifier_gain_adjust <= 4'h0;
		end else if (running) begin
			gain_polarity <= w_an[`SCWD_GAIN_POL];
			gain_magnitude <= w_an[`SCWD_GAIN_HI:`SCWD_GAIN_LO];
			amplifier_gain_adjust <= w_an[`SCWD_GAIN_POL:`SCWD_GAIN_LO];
		end
	end

	// feedback is on for every tail code; kept in a flop so the output is registered
	// tail current shift
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tail_current_shift <= 2'h0;
			osc_feedback_enable <= 1'b1;
		end else if (running) begin
			tail_current_shift <= w_an[`SCWD_OSCILLATOR_TAIL_CURRENT_HI:`SCWD_OSCILLATOR_TAIL_CURRENT_LO];
			osc_feedback_enable <= 1'b1;
		end
	end

	// reserved rate codes fall back to the slowest divide so the adcs
	// keep sampling at a safe rate rather than stopping
	// rate code range
	assign rate_reserved = (w_an[`SCWD_RATE_HI:0] < `SCWD_RATE_MIN) ||
		(w_an[`SCWD_RATE_HI:0] > `SCWD_RATE_MAX);
	assign div_shift = rate_reserved ? `SCWD_DIV_SHIFT_DEF :
		(w_an[`SCWD_RATE_HI:0] + `SCWD_DIV_SHIFT_OFS);
	assign div_limit = 6'((7'h01 << div_shift) - 7'h01);

	// raw code is passed on even when reserved; the divider applies its own fallback
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			update_rate_select <= 3'h0;
		end else if (running) begin
			update_rate_select <= w_an[`SCWD_RATE_HI:0];
		end
	end

	// a rate change applies to the period in progress if the count is below
	// the new limit, otherwise the counter restarts at once
	// sampling divider
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			div_cnt_r <= 6'h00;
			adc_sample_tick <= 1'b0;
		end else if (!running) begin
			div_cnt_r <= 6'h00;
			adc_sample_tick <= 1'b0;
		end else if (div_cnt_r >= div_limit) begin
			div_cnt_r <= 6'h00;
			adc_sample_tick <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 6'h01;
			adc_sample_tick <= 1'b0;
		end
	end

	// same compare as the adc tick, so both pulses fall in one cycle
	// pwm at update rate
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pwm_period_tick <= 1'b0;
		end else begin
			pwm_period_tick <= running && (div_cnt_r >= div_limit);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			digital_filter_fir <= 1'b0;
		end else if (running) begin
			digital_filter_fir <= w_ca[`SCWD_FILT_BIT];
		end
	end

	// coil samples stay zero until the swap setting has been loaded
	// coil input swap
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cosine_path <= 13'h0000;
			sine_path <= 13'h0000;
		end else if (!running) begin
			cosine_path <= 13'h0000;
			sine_path <= 13'h0000;
		end else if (w_ca[`SCWD_SWAP_BIT]) begin
			cosine_path <= second_coil_input;
			sine_path <= first_coil_input;
		end else begin
			cosine_path <= first_coil_input;
			sine_path <= second_coil_input;
		end
	end

	// fields spanning two words take their upper bits from the lower-index word
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			gain_mismatch_correction <= 7'sh00;
			ch1_dynamic_offset <= 10'sh000;
			ch1_static_offset <= 10'sh000;
			ch2_offset_a <= 10'sh000;
			ch2_offset_b <= 10'sh000;
		end else if (running) begin
			gain_mismatch_correction <= w_ca[13:7];
			ch1_dynamic_offset <= {w_ca[6:0], w_cb[15:13]};
			ch1_static_offset <= w_cb[12:3];
			ch2_offset_a <= {w_cb[2:0], w_cc[15:9]};
			ch2_offset_b <= {w_cc[8:0], w_cd[15]};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			serial_protocol_select <= 4'h0;
			frame_length_ticks <= 11'h000;
			pause_pulse_enable <= 1'b0;
			psi_error_check_select <= 1'b0;
		end else if (running) begin
			// protocol code is only stored; framing belongs to the output logic
			serial_protocol_select <= w_se[15:12];
			frame_length_ticks <= w_se[11:1];
			pause_pulse_enable <= w_se[0];
			psi_error_check_select <= w_pa[`SCWD_ERRCS_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			threshold_source_select <= 2'h0;
			output_selection <= 15'h0000;
			watchdog_scale <= 3'h0;
		end else if (running) begin
			threshold_source_select <= w_oc[3:2];
			// bit 0 of this word is the oscillator dac control, not decoded here
			output_selection <= word_r[`SCWD_W_OUTPUT_SELECTION][15:1];
			// the block does not enforce the advised pairing with the rate
			// watchdog scale passed on
			watchdog_scale <= word_r[`SCWD_W_MISC][13:11];
		end
	end

	// reserved code flag
	// each coded field is checked on its own so a new bound is a one-line change
	assign proto_reserved = (w_se[15:12] > `SCWD_PROTO_MAX);
	assign psi_frame_reserved = (w_pa[11:9] > `SCWD_PSIFR_MAX);
	assign psi_status_reserved = (w_pa[8:7] > `SCWD_PSISTS_MAX);
	assign region_b_reserved = (w_pa[3:0] > `SCWD_DRB_MAX);
	assign region_a_reserved = (w_pb[15:12] > `SCWD_DRA_MAX);
	assign code_reserved = rate_reserved || proto_reserved || psi_frame_reserved ||
		psi_status_reserved || region_b_reserved || region_a_reserved;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_reserved_code <= 1'b0;
		end else begin
			cfg_reserved_code <= running && code_reserved;
		end
	end
endmodule

`default_nettype wire

// file: shared/scwd_consts.svh
// constants for the sensor configuration word decoder
// assumes a 16-bit word store of 32 words reached by word index
`ifndef SCWD_CONSTS_SVH
`define SCWD_CONSTS_SVH

`define SCWD_WORD_COUNT 32
`define SCWD_ADDR_W 5
`define SCWD_DATA_W 16
`define SCWD_COIL_W 13

// word indices of the configuration store
`define SCWD_W_ANALOG 5'h01
`define SCWD_W_CORR_A 5'h02
`define SCWD_W_CORR_B 5'h03
`define SCWD_W_CORR_C 5'h04
`define SCWD_W_CORR_D 5'h05
`define SCWD_W_SERIAL 5'h16
`define SCWD_W_PSI_A 5'h17
`define SCWD_W_PSI_B 5'h18
`define SCWD_W_OUTPUT_SELECTION 5'h19
`define SCWD_W_OSC 5'h1a
`define SCWD_W_MSG 5'h1b
`define SCWD_W_USER_MESSAGE_ID 5'h1c
`define SCWD_W_MISC 5'h1d

// reset image of the words that carry a non-zero default
`define SCWD_RST_ANALOG 16'h0003
`define SCWD_RST_OUTPUT_SELECTION 16'he000
`define SCWD_RST_USER_MESSAGE_ID 16'h00ff
`define SCWD_RST_MISC 16'h8800

// field positions
`define SCWD_GAIN_POL 10
`define SCWD_GAIN_HI 9
`define SCWD_GAIN_LO 7
`define SCWD_OSCILLATOR_TAIL_CURRENT_HI 6
`define SCWD_OSCILLATOR_TAIL_CURRENT_LO 5
`define SCWD_RATE_HI 2
`define SCWD_FILT_BIT 15
`define SCWD_SWAP_BIT 14
`define SCWD_ERRCS_BIT 4

// update-rate codes and the divide shifts they select
`define SCWD_RATE_MIN 3'h3
`define SCWD_RATE_MAX 3'h6
`define SCWD_DIV_SHIFT_OFS 3'h0
`define SCWD_DIV_SHIFT_DEF 3'h6

// reserved bounds of coded fields
`define SCWD_PROTO_MAX 4'hc
`define SCWD_PSIFR_MAX 3'h4
`define SCWD_PSISTS_MAX 2'h2
`define SCWD_DRB_MAX 4'hc
`define SCWD_DRA_MAX 4'he

// cycles spent copying the store into the shadow registers after reset
`define SCWD_LOAD_CYCLES 6'h20

`endif

// file: shared/scwd_pkg.sv
// types shared by the sensor configuration word decoder
// assumes the constants header is included where needed
package scwd_pkg;
	typedef enum logic [0:0] {
		SCWD_LOAD,
		SCWD_RUN
	} scwd_state_type;
	typedef logic [15:0] scwd_word_type;
endpackage

// file: test/scwd_decoder_sva.sv
// assertions on the ports of the configuration word decoder
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module scwd_decoder_sva (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [12:0] first_coil_input,
	input wire logic [12:0] second_coil_input,
	input wire logic cfg_ready,
	input wire logic cfg_reserved_code,
	input wire logic gain_polarity,
	input wire logic [2:0] gain_magnitude,
	input wire logic [3:0] amplifier_gain_adjust,
	input wire logic osc_feedback_enable,
	input wire logic [2:0] update_rate_select,
	input wire logic adc_sample_tick,
	input wire logic pwm_period_tick,
	input wire logic [12:0] cosine_path,
	input wire logic [12:0] sine_path,
	input wire logic [10:0] frame_length_ticks
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic [7:0] gap_r;
	logic gap_ok_r;
	// gap is only trusted once a whole period has run at one rate
	always_ff @(posedge sys_clk) begin
		gap_r <= (srst || adc_sample_tick) ? 8'h01 : gap_r + 8'h01;
	end
	always_ff @(posedge sys_clk) begin
		if (srst || !cfg_ready || $changed(update_rate_select)) begin
			gap_ok_r <= 1'b0;
		end else if (adc_sample_tick) begin
			gap_ok_r <= 1'b1;
		end
	end
	AST_GAIN_SPLIT: assert property (amplifier_gain_adjust == {gain_polarity, gain_magnitude})
		else $error("gain split mismatch");
	AST_FB_ON: assert property (osc_feedback_enable)
		else $error("feedback dropped");
	AST_PWM_EQ: assert property (pwm_period_tick == adc_sample_tick)
		else $error("pwm tick differs from adc tick");
	AST_TICK_GAP: assert property (adc_sample_tick && gap_ok_r && $stable(update_rate_select)
		&& update_rate_select >= 3'h3 && update_rate_select <= 3'h6
		|-> gap_r == (8'h01 << update_rate_select)) else $error("tick period wrong");
	AST_READY_HOLD: assert property (cfg_ready |=> cfg_ready)
		else $error("ready dropped");
	AST_LOAD: assert property ($fell(srst) |-> !cfg_ready [*8] ##[24:26] cfg_ready)
		else $error("load length wrong");
	AST_HIDE: assert property (!cfg_ready |-> cosine_path == 13'h0 && sine_path == 13'h0
		&& frame_length_ticks == 11'h0) else $error("settings visible before ready");
	AST_SWAP: assert property (cfg_ready && $past(cfg_ready) |->
		(cosine_path == $past(first_coil_input) && sine_path == $past(second_coil_input)) ||
		(cosine_path == $past(second_coil_input) && sine_path == $past(first_coil_input)))
		else $error("coil path not from inputs");
	AST_RATE_RSVD: assert property (cfg_ready && (update_rate_select < 3'h3 ||
		update_rate_select > 3'h6) |-> cfg_reserved_code) else $error("reserved rate not flagged");
	AST_RD_ONE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
		else $error("read data held too long");
endmodule
bind scwd_decoder scwd_decoder_sva u_scwd_decoder_sva (.*);
`default_nettype wire

// file: test/scwd_decoder_tb.sv
// self-checking bench for the configuration word decoder
// assumes the decoder alone, driven at rising edges of a 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
module scwd_decoder_tb;
	logic sys_clk, srst, reg_wr, reg_rd, cfg_ready, cfg_reserved_code, gain_polarity;
	logic osc_feedback_enable, adc_sample_tick, pwm_period_tick, digital_filter_fir;
	logic pause_pulse_enable, psi_error_check_select;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [12:0] first_coil_input, second_coil_input, cosine_path, sine_path;
	logic [2:0] gain_magnitude, update_rate_select, watchdog_scale;
	logic [3:0] amplifier_gain_adjust, serial_protocol_select;
	logic [1:0] tail_current_shift, threshold_source_select;
	logic signed [6:0] gain_mismatch_correction;
	logic signed [9:0] ch1_dynamic_offset, ch1_static_offset, ch2_offset_a, ch2_offset_b;
	logic [10:0] frame_length_ticks;
	logic [14:0] output_selection;
	localparam logic signed [6:0] GM = 7'h41;
	localparam logic signed [9:0] DC = 10'h2a5;
	localparam logic signed [9:0] SC = 10'h35a;
	localparam logic signed [9:0] CA = 10'h1c3;
	localparam logic signed [9:0] CB = 10'h301;
	int err_count = 0;
	int checks = 0;
	scwd_decoder u_scwd_decoder (.*);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// returns just after the decoded outputs have taken the new word
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string nm);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, reg_rdata, exp);
	endtask
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (adc_sample_tick !== 1'b1 && n < 200);
		if (n >= 200) begin
			err_count++;
			end_sim();
		end
	endtask
	task automatic t_defaults();
		chk("rate", update_rate_select, 3'h3);
		chk("wd scale", watchdog_scale, 3'h1);
		chk("out sel", output_selection, 15'h7000);
		chk("td src", threshold_source_select, 2'h0);
		chk("gain code", amplifier_gain_adjust, 4'h0);
		rd(5'h19, 16'he000, "w25");
		rd(5'h1c, 16'h00ff, "w28");
	endtask
	task automatic t_gain_tail();
		logic [3:0] g;
		for (int i = 0; i < 4; i++) begin
			g = i[0] ? 4'h7 : 4'h8;
			wr(5'h01, {5'h0, g, i[1:0], 2'h0, 3'h3});
			chk("polarity", gain_polarity, g[3]);
			chk("magnitude", gain_magnitude, g[2:0]);
			chk("gain code", amplifier_gain_adjust, g);
			chk("tail", tail_current_shift, i[1:0]);
			chk("feedback", osc_feedback_enable, 1'b1);
		end
	endtask
	task automatic t_rate();
		int n;
		logic [2:0] ws;
		for (int r = 3; r < 7; r++) begin
			wr(5'h01, {13'h0, r[2:0]});
			chk("rate", update_rate_select, r[2:0]);
			// watchdog scale set as advised for this update rate
			ws = (r < 5) ? 3'h1 : 3'(r - 3);
			wr(5'h1d, {2'h2, ws, 11'h000});
			chk("wd scale", watchdog_scale, ws);
			// the first gap after a change may be cut short
			repeat (2) wait_tick(n);
			chk("pwm", pwm_period_tick, 1'b1);
			wait_tick(n);
			chk("gap", n[15:0], 16'h1 << r);
		end
		wr(5'h01, 16'h0007);
		chk("rsvd rate", cfg_reserved_code, 1'b1);
		wr(5'h01, 16'h0003);
		chk("rate ok", cfg_reserved_code, 1'b0);
	endtask
	task automatic t_corr();
		for (int s = 0; s < 2; s++) begin
			wr(5'h02, {s[0], s[0], GM, DC[9:3]});
			@(posedge sys_clk);
			first_coil_input <= 13'h0123;
			second_coil_input <= 13'h1abc;
			@(posedge sys_clk);
			#1;
			chk("fir", digital_filter_fir, s[0]);
			chk("cos", cosine_path, s[0] ? 13'h1abc : 13'h0123);
			chk("sin", sine_path, s[0] ? 13'h0123 : 13'h1abc);
		end
		wr(5'h03, {DC[2:0], SC, CA[9:7]});
		wr(5'h04, {CA[6:0], CB[9:1]});
		wr(5'h05, {CB[0], 15'h0});
		chk("gain_mismatch_correction", gain_mismatch_correction, GM);
		chk("ch1_dynamic_offset", ch1_dynamic_offset, DC);
		chk("ch1_static_offset", ch1_static_offset, SC);
		chk("ch2a", ch2_offset_a, CA);
		chk("ch2b", ch2_offset_b, CB);
	endtask
	task automatic t_serial();
		wr(5'h16, 16'h0fff);
		chk("frame", frame_length_ticks, 11'h7ff);
		chk("pause", pause_pulse_enable, 1'b1);
		wr(5'h17, 16'h0010);
		chk("errcs", psi_error_check_select, 1'b1);
		for (int t = 0; t < 4; t++) begin
			wr(5'h1a, {12'h0, t[1:0], 2'h0});
			chk("td src", threshold_source_select, t[1:0]);
		end
		wr(5'h17, 16'h090c);
		chk("psi max", cfg_reserved_code, 1'b0);
		wr(5'h17, 16'h0a00);
		chk("psi frame", cfg_reserved_code, 1'b1);
		wr(5'h17, 16'h0180);
		chk("psi status", cfg_reserved_code, 1'b1);
		wr(5'h17, 16'h000d);
		chk("psi region b", cfg_reserved_code, 1'b1);
		wr(5'h17, 16'h0000);
		wr(5'h18, 16'he000);
		chk("region a max", cfg_reserved_code, 1'b0);
		wr(5'h18, 16'hf000);
		chk("region a", cfg_reserved_code, 1'b1);
		wr(5'h18, 16'h0000);
		wr(5'h16, 16'hc000);
		chk("proto max", cfg_reserved_code, 1'b0);
		wr(5'h16, 16'hd000);
		chk("rsvd proto", cfg_reserved_code, 1'b1);
		chk("proto", serial_protocol_select, 4'hd);
		chk("frame", frame_length_ticks, 11'h0);
		// reserved words are left as they were; a user word shows verbatim storage
		wr(5'h1b, 16'ha5c3);
		rd(5'h1b, 16'ha5c3, "message word");
		rd(5'h1e, 16'h0000, "rsvd word");
	endtask
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h0;
		reg_wdata = 16'h0;
		first_coil_input = 13'h0;
		second_coil_input = 13'h0;
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		chk("early", cfg_ready, 1'b0);
		for (int k = 0; k < 100 && cfg_ready !== 1'b1; k++) begin
			@(posedge sys_clk);
			#1;
		end
		chk("ready", cfg_ready, 1'b1);
		if (cfg_ready !== 1'b1) begin
			end_sim();
		end
		t_defaults();
		t_gain_tail();
		t_rate();
		t_corr();
		t_serial();
		end_sim();
	end
endmodule
`default_nettype wire
